// ### common/cpe_map.vh
`ifndef CPE_MAP_VH
`define CPE_MAP_VH
// Overview of operation
// RULE1: three stages: fetch, decode, execute.
// RULE2: execute holds arithmetic/logic, multiply and load/store sections in parallel.
// RULE3: instructions issue and retire strictly in program order.
// RULE4: multi-cycle operations hold decode and execute; younger instructions wait.
// RULE5: no forwarding; operands read in execute so no data hazard arises.
// RULE6: no shadow banks or return registers; context lives on the stack.
// RULE7: interrupt entry pushes general registers eight to twelve onto the stack.
// RULE8: that push happens for every interrupt, whatever its priority.
// RULE9: interrupt entry also pushes return address and status register.
// RULE10: interrupt return restores registers eight to twelve, status, then resumes.
// RULE11: exception or system call entry saves status and return address only.
// RULE12: exception or system call return pops status and resumes at popped address.
// RULE13: every memory access is checked against current privilege; the code checks fetches and loads/stores only, not frame pushes or pops.
// RULE14: forbidden accesses are aborted without effect and raise an exception.
// RULE15: unaligned accesses rejected except word-aligned doubleword loads and stores.
// RULE16: other unaligned accesses raise an address exception.
// RULE17: word-aligned doubleword access runs as two consecutive word accesses.
// RULE18: halfword needs bit 0 clear; word and doubleword need bits 1:0 clear.
// RULE19: pushes finish before handler fetch; faulting access changes nothing.
// =====================================================
// instruction fields
`define F_OP 31:28
`define F_RD 27:24
`define F_RA 23:20
`define F_RB 19:16
`define F_SZ 17:16
`define F_IMM 15:0
`define F_IMM_MSB 15
`define IMM_EXT 16
// opcodes
`define OP_NOP 4'h0
`define OP_ADD 4'h1
`define OP_SUB 4'h2
`define OP_AND 4'h3
`define OP_OR 4'h4
`define OP_ADDI 4'h5
`define OP_MUL 4'h6
`define OP_LD 4'h7
`define OP_ST 4'h8
`define OP_SCALL 4'h9
`define OP_RETE 4'hA
`define OP_RETS 4'hB
`define OP_MTSR 4'hC
// access sizes
`define SZ_B 2'h0
`define SZ_H 2'h1
`define SZ_W 2'h2
`define SZ_D 2'h3
`define MASK_B 32'h000000FF
`define MASK_H 32'h0000FFFF
`define WORD_STEP 32'h00000004
// status register bits
`define SR_GM 16
`define SR_PRIV 22
`define SR_INT 23
`define SR_RESET 32'h00400000
// state codes
`define ST_IDLE 3'h0
`define ST_MUL 3'h1
`define ST_MEM 3'h2
`define ST_PUSH 3'h3
`define ST_POP 3'h4
// counts, frame layout and addresses
`define MUL_CYCLES 3'h3
`define FR_LAST_IRQ 3'h6
`define FR_LAST_EXC 3'h1
`define FR_SR 3'h0
`define FR_RET 3'h1
`define SCR_BIAS 4'h6
`define SP_IDX 4'hD
`define SP_RESET 32'h00010000
`define RESET_PC 32'h80000000
`define EVBA 32'h80001000
`define OFS_PROT 32'h00000014
`define OFS_ADDR 32'h00000018
`define OFS_SCALL 32'h00000100
`define USER_TOP 32'hF0000000
`endif

// ### rtl/cpe_core.v
`include "cpe_map.vh"

module cpe_core (
  input wire clk, // system clock
  input wire rst_n, // async reset, low
  input wire ce, // clock enable, freezes all
  output reg imem_req, // fetch request, level
  output reg [31:0] imem_addr, // fetch address
  input wire imem_ack, // fetch data valid
  input wire [31:0] imem_rdata, // fetched word
  output reg dmem_req, // data request, level
  output reg dmem_we, // data write
  output reg [1:0] dmem_size, // byte/half/word
  output reg [31:0] dmem_addr, // data address
  output reg [31:0] dmem_wdata, // write data
  input wire dmem_ack, // data access done
  input wire [31:0] dmem_rdata, // read data, low aligned
  input wire irq_req, // interrupt pending
  input wire [13:0] irq_offset, // autovector offset
  output reg irq_ack, // interrupt taken pulse
  output reg retire, // instruction retired pulse
  output reg [31:0] retire_pc, // address of retired one
  output wire [31:0] status // status register
);

  // =====================================================
  // state
  reg [31:0] rf [0:15];
  reg [31:0] sr;
  reg [31:0] fpc;
  reg f_busy;
  reg f_drop;
  reg if_v;
  reg if_flt;
  reg [31:0] if_ins;
  reg [31:0] if_pc;
  reg id_v;
  reg id_flt;
  reg [31:0] id_ins;
  reg [31:0] id_pc;
  reg ex_v;
  reg ex_flt;
  reg [31:0] ex_ins;
  reg [31:0] ex_pc;
  reg [2:0] state;
  reg [2:0] cnt;
  reg [2:0] last;
  reg hi;
  reg [31:0] seq_ret;
  reg [31:0] seq_tgt;
  reg [31:0] seq_sr;
  reg [31:0] seq_nsr;
  integer i;

  assign status = sr;

  // =====================================================
  // execute-stage decode; operands come straight from the
  // register file here, so nothing older is still in flight
  wire [3:0] op = ex_ins[`F_OP];
  wire [3:0] rd = ex_ins[`F_RD];
  wire [3:0] ra = ex_ins[`F_RA];
  wire [3:0] rb = ex_ins[`F_RB];
  wire [3:0] rd1 = rd + 4'h1;
  wire [1:0] sz = ex_ins[`F_SZ];
  wire [31:0] simm = {{`IMM_EXT{ex_ins[`F_IMM_MSB]}}, ex_ins[`F_IMM]};
  wire [31:0] va = rf[ra]; // RULE5
  wire [31:0] vb = rf[rb];
  wire [31:0] vd = rf[rd];
  wire [31:0] sp = rf[`SP_IDX];
  wire [63:0] prod = va * vb;
  wire [31:0] ea = va + simm;
  wire [31:0] ea_end = (sz == `SZ_D) ? ea + `WORD_STEP : ea;
  wire user = ~sr[`SR_PRIV];
  wire is_mem = (op == `OP_LD) | (op == `OP_ST);
  wire is_sys = (op == `OP_SCALL) | (op == `OP_RETE) | (op == `OP_RETS);

  // alignment: doubleword only needs word alignment
  wire mis_h = (sz == `SZ_H) & ea[0]; // RULE18
  wire mis_w = sz[1] & (ea[1:0] != 2'h0); // RULE18 RULE15
  wire mis = mis_h | mis_w; // RULE16
  // user code may not touch the top region, either half of a pair
  wire prot = user & ((ea >= `USER_TOP) | (ea_end >= `USER_TOP)); // RULE13

  // =====================================================
  // event and hand-off decisions
  wire at_ex = (state == `ST_IDLE) & ex_v;
  wire exc = at_ex & (ex_flt | (is_mem & (mis | prot))); // RULE14 RULE16
  wire sys = at_ex & ~ex_flt & is_sys;
  // interrupts only between instructions: execute empty, next one waiting
  wire take_irq = irq_req & ~sr[`SR_GM] & (state == `ST_IDLE) & ~ex_v & id_v;
  wire ev_start = take_irq | exc | sys;
  wire ex_one = at_ex & ~exc & ~sys & (op != `OP_MUL) & ~is_mem;
  wire ex_take = ~ex_v | ex_one; // RULE4
  wire id_free = ~id_v | ex_take; // RULE4
  wire seq = (state == `ST_PUSH) | (state == `ST_POP);
  wire redir = seq & dmem_ack & (cnt == last);
  wire [31:0] redir_pc = (state == `ST_POP) ?
    ((cnt == `FR_RET) ? dmem_rdata : seq_ret) : seq_tgt;
  // fetch stays quiet until the whole frame is on the stack
  wire f_en = ~seq & ~ev_start; // RULE19

  // frame word k: 0 status, 1 return address, 2..6 scratch registers
  function [31:0] push_val;
    input [2:0] k;
    input [31:0] r;
    input [31:0] s;
    begin
      if (k == `FR_SR) begin
        push_val = s;
      end else if (k == `FR_RET) begin
        push_val = r;
      end else begin
        push_val = rf[{1'b0, k} + `SCR_BIAS]; // RULE7
      end
    end
  endfunction

  // =====================================================
  // fetch and decode stages
  always @(posedge clk or negedge rst_n) begin // RULE1
    if (!rst_n) begin
      fpc <= `RESET_PC;
      f_busy <= 1'b0;
      f_drop <= 1'b0;
      imem_req <= 1'b0;
      imem_addr <= 32'h00000000;
      if_v <= 1'b0;
      if_flt <= 1'b0;
      if_ins <= 32'h00000000;
      if_pc <= 32'h00000000;
      id_v <= 1'b0;
      id_flt <= 1'b0;
      id_ins <= 32'h00000000;
      id_pc <= 32'h00000000;
    end else if (ce) begin
      // younger work is thrown away when an event starts
      if (ev_start) begin
        if_v <= 1'b0;
        id_v <= 1'b0;
      end else if (id_free) begin // RULE3
        id_v <= if_v;
        id_ins <= if_ins;
        id_pc <= if_pc;
        id_flt <= if_flt;
        if_v <= 1'b0;
      end
      // one fetch outstanding; a flushed reply is dropped
      if (f_busy) begin
        if (imem_ack) begin
          f_busy <= 1'b0;
          imem_req <= 1'b0;
          f_drop <= 1'b0;
          if (~f_drop & ~ev_start) begin
            if_v <= 1'b1;
            if_ins <= imem_rdata;
            if_pc <= imem_addr;
            if_flt <= 1'b0;
            fpc <= imem_addr + `WORD_STEP;
          end
        end else if (ev_start) begin
          f_drop <= 1'b1;
        end
      end else if (f_en & ~if_v) begin
        if (user & (fpc >= `USER_TOP)) begin // RULE13
          // forbidden fetch never reaches the bus
          if_v <= 1'b1; // RULE14
          if_flt <= 1'b1;
          if_ins <= 32'h00000000;
          if_pc <= fpc;
        end else begin
          f_busy <= 1'b1;
          imem_req <= 1'b1;
          imem_addr <= fpc;
        end
      end
      if (redir) begin
        fpc <= redir_pc;
      end
    end
  end

  // =====================================================
  // start an event frame; status changes only once it is stored
  task start_push;
    input [2:0] top;
    input [31:0] ret;
    input [31:0] tgt;
    input [31:0] nsr;
    begin
      seq_sr <= sr; // RULE6
      seq_ret <= ret;
      seq_tgt <= tgt;
      seq_nsr <= nsr;
      cnt <= top;
      last <= `FR_SR;
      state <= `ST_PUSH;
      dmem_req <= 1'b1;
      dmem_we <= 1'b1;
      dmem_size <= `SZ_W;
      dmem_addr <= sp - `WORD_STEP;
      dmem_wdata <= push_val(top, ret, sr);
      rf[`SP_IDX] <= sp - `WORD_STEP;
    end
  endtask

  // =====================================================
  // execute stage: alu, multiply, load/store, event sequencer
  always @(posedge clk or negedge rst_n) begin // RULE2
    if (!rst_n) begin
      for (i = 0; i < 16; i = i + 1) begin
        rf[i] <= 32'h00000000;
      end
      rf[`SP_IDX] <= `SP_RESET;
      sr <= `SR_RESET;
      state <= `ST_IDLE;
      ex_v <= 1'b0;
      ex_flt <= 1'b0;
      ex_ins <= 32'h00000000;
      ex_pc <= 32'h00000000;
      cnt <= 3'h0;
      last <= 3'h0;
      hi <= 1'b0;
      seq_ret <= 32'h00000000;
      seq_tgt <= 32'h00000000;
      seq_sr <= 32'h00000000;
      seq_nsr <= 32'h00000000;
      dmem_req <= 1'b0;
      dmem_we <= 1'b0;
      dmem_size <= `SZ_W;
      dmem_addr <= 32'h00000000;
      dmem_wdata <= 32'h00000000;
      irq_ack <= 1'b0;
      retire <= 1'b0;
      retire_pc <= 32'h00000000;
    end else if (ce) begin
      irq_ack <= 1'b0;
      retire <= 1'b0;
      if (ev_start) begin
        ex_v <= 1'b0;
      end else if (ex_take) begin // RULE3
        ex_v <= id_v;
        ex_ins <= id_ins;
        ex_pc <= id_pc;
        ex_flt <= id_flt;
      end
      case (state)
        `ST_IDLE: begin
          if (take_irq) begin
            // full frame for every interrupt, priority plays no part
            start_push(`FR_LAST_IRQ, id_pc, `EVBA + {18'h00000, irq_offset},
              sr | (32'h1 << `SR_PRIV) | (32'h1 << `SR_GM) | (32'h1 << `SR_INT)); // RULE8 RULE9
            irq_ack <= 1'b1;
          end else if (exc) begin
            // fault frame: status and faulting address, no registers touched
            start_push(`FR_LAST_EXC, ex_pc,
              `EVBA + ((~ex_flt & mis) ? `OFS_ADDR : `OFS_PROT),
              (sr | (32'h1 << `SR_PRIV) | (32'h1 << `SR_GM)) & ~(32'h1 << `SR_INT)); // RULE11 RULE19
          end else if (sys & (op == `OP_SCALL)) begin
            start_push(`FR_LAST_EXC, ex_pc + `WORD_STEP, `EVBA + `OFS_SCALL,
              (sr | (32'h1 << `SR_PRIV) | (32'h1 << `SR_GM)) & ~(32'h1 << `SR_INT)); // RULE11
          end else if (sys) begin
            // interrupt frames are longer; the context bit tells which
            last <= ((op == `OP_RETE) & sr[`SR_INT]) ? `FR_LAST_IRQ : `FR_LAST_EXC; // RULE10 RULE12
            cnt <= `FR_SR;
            state <= `ST_POP;
            dmem_req <= 1'b1;
            dmem_we <= 1'b0;
            dmem_size <= `SZ_W;
            dmem_addr <= sp;
          end else if (at_ex) begin
            case (op)
              `OP_MUL: begin
                cnt <= `MUL_CYCLES - 3'h1; // RULE4
                state <= `ST_MUL;
              end
              `OP_LD, `OP_ST: begin
                hi <= 1'b0;
                state <= `ST_MEM;
                dmem_req <= 1'b1;
                dmem_we <= (op == `OP_ST);
                dmem_size <= (sz == `SZ_D) ? `SZ_W : sz; // RULE17
                dmem_addr <= ea;
                dmem_wdata <= vd;
              end
              `OP_ADD: begin
                rf[rd] <= va + vb;
              end
              `OP_SUB: begin
                rf[rd] <= va - vb;
              end
              `OP_AND: begin
                rf[rd] <= va & vb;
              end
              `OP_OR: begin
                rf[rd] <= va | vb;
              end
              `OP_ADDI: begin
                rf[rd] <= ea;
              end
              `OP_MTSR: begin
                // user code cannot raise its own privilege
                if (~user) begin
                  sr <= va;
                end
              end
              default: begin
              end
            endcase
            if (ex_one) begin
              retire <= 1'b1;
              retire_pc <= ex_pc;
            end
          end
        end
        `ST_MUL: begin
          // decode keeps the next instruction until this one leaves
          if (cnt == 3'h0) begin
            rf[rd] <= prod[31:0];
            state <= `ST_IDLE;
            ex_v <= 1'b0;
            retire <= 1'b1;
            retire_pc <= ex_pc;
          end else begin
            cnt <= cnt - 3'h1; // RULE4
          end
        end
        `ST_MEM: begin
          if (dmem_ack) begin
            if (op == `OP_LD) begin
              rf[hi ? rd1 : rd] <= dmem_rdata &
                ((sz == `SZ_B) ? `MASK_B : (sz == `SZ_H) ? `MASK_H : ~32'h0);
            end
            if ((sz == `SZ_D) & ~hi) begin
              // second word of the pair, next address up
              hi <= 1'b1; // RULE17
              dmem_addr <= dmem_addr + `WORD_STEP;
              dmem_wdata <= rf[rd1];
            end else begin
              dmem_req <= 1'b0;
              dmem_we <= 1'b0;
              state <= `ST_IDLE;
              ex_v <= 1'b0;
              retire <= 1'b1;
              retire_pc <= ex_pc;
            end
          end
        end
        `ST_PUSH: begin
          if (dmem_ack) begin
            if (cnt == last) begin
              // frame complete: enter handler context
              dmem_req <= 1'b0; // RULE19
              dmem_we <= 1'b0;
              sr <= seq_nsr;
              state <= `ST_IDLE;
            end else begin
              cnt <= cnt - 3'h1; // RULE7 RULE9
              dmem_addr <= sp - `WORD_STEP;
              dmem_wdata <= push_val(cnt - 3'h1, seq_ret, seq_sr);
              rf[`SP_IDX] <= sp - `WORD_STEP;
            end
          end
        end
        `ST_POP: begin
          if (dmem_ack) begin
            if (cnt == `FR_SR) begin
              seq_sr <= dmem_rdata;
            end else if (cnt == `FR_RET) begin
              seq_ret <= dmem_rdata;
            end else begin
              rf[{1'b0, cnt} + `SCR_BIAS] <= dmem_rdata; // RULE10
            end
            rf[`SP_IDX] <= sp + `WORD_STEP;
            if (cnt == last) begin
              dmem_req <= 1'b0;
              sr <= seq_sr; // RULE12
              state <= `ST_IDLE;
            end else begin
              cnt <= cnt + 3'h1;
              dmem_addr <= sp + `WORD_STEP;
            end
          end
        end
        default: begin
          state <= `ST_IDLE;
        end
      endcase
    end
  end

endmodule // cpe_core

// ### verif/cpe_core_chk.sv
`include "cpe_map.vh"
// ==========
// bus and event-entry checks
module cpe_core_chk (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, low
  input wire logic imem_req, // fetch req
  input wire logic [31:0] imem_addr, // fetch addr
  input wire logic imem_ack, // fetch done
  input wire logic dmem_req, // data req
  input wire logic dmem_we, // data write
  input wire logic [1:0] dmem_size, // size
  input wire logic [31:0] dmem_addr, // data addr
  input wire logic [31:0] dmem_wdata, // write data
  input wire logic dmem_ack, // data done
  input wire logic [13:0] irq_offset, // handler offset
  input wire logic irq_ack, // irq taken
  input wire logic [31:0] status // status
);
  logic [2:0] push_left;
  logic [31:0] hoff;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // frame words still owed; the handler fetch must not start before they land
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      push_left <= 3'h0;
      hoff <= 32'h0;
    end else if (irq_ack) begin
      push_left <= 3'h7;
      hoff <= `EVBA + {18'h0, irq_offset};
    end else if (dmem_ack && push_left != 3'h0) begin
      push_left <= push_left - 3'h1;
    end
  end
  a_fetch_hold: assert property (imem_req && !imem_ack |=> imem_req && $stable(imem_addr))
    else $error("fetch request moved before ack");
  a_data_hold: assert property (dmem_req && !dmem_ack |=> dmem_req
    && $stable({dmem_we, dmem_size, dmem_addr, dmem_wdata}))
    else $error("data request moved before ack");
  a_no_dword: assert property (dmem_req |-> dmem_size != `SZ_D)
    else $error("doubleword on the bus");
  a_half_align: assert property (dmem_req && dmem_size == `SZ_H |-> !dmem_addr[0])
    else $error("odd halfword access");
  a_word_align: assert property (dmem_req && dmem_size == `SZ_W |-> dmem_addr[1:0] == 2'h0)
    else $error("unaligned word access");
  a_user_region: assert property (dmem_req && !status[`SR_PRIV] |-> dmem_addr < `USER_TOP)
    else $error("user access to guarded region");
  a_irq_unmasked: assert property (irq_ack |-> !$past(status[`SR_GM]) ##1 !irq_ack)
    else $error("irq taken while masked or ack too long");
  a_push_start: assert property (irq_ack |-> dmem_req && dmem_we && dmem_size == `SZ_W)
    else $error("frame push not started with ack");
  a_push_first: assert property (push_left != 3'h0 |->
    dmem_we && !(imem_req && imem_addr == hoff))
    else $error("handler fetch before frame pushed");
  a_handler_go: assert property (irq_ack |-> ##[7:90] (imem_req && imem_addr == hoff))
    else $error("handler not fetched in time");
  a_sr_entry: assert property ($rose(status[`SR_INT]) |-> status[`SR_GM] && status[`SR_PRIV])
    else $error("entry status lacks mask or privilege");
  a_int_exit: assert property ($fell(status[`SR_INT]) |-> $past(dmem_ack))
    else $error("status restored away from last pop");
endmodule // cpe_core_chk
bind cpe_core cpe_core_chk u_chk (.clk(clk), .rst_n(rst_n), .imem_req(imem_req),
  .imem_addr(imem_addr), .imem_ack(imem_ack), .dmem_req(dmem_req), .dmem_we(dmem_we),
  .dmem_size(dmem_size), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_ack(dmem_ack),
  .irq_offset(irq_offset), .irq_ack(irq_ack), .status(status));

// ### verif/cpe_mem_model.sv
`include "cpe_map.vh"
// ==========
// memory system and interrupt source
module cpe_mem_model #(
  parameter logic [13:0] IRQ_OFS = 14'h0200
) (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, low
  input wire logic [1:0] max_wait, // longest wait
  input wire logic irq_go, // raise one irq
  input wire logic imem_req, // fetch req
  input wire logic [31:0] imem_addr, // fetch addr
  output logic imem_ack, // fetch done
  output logic [31:0] imem_rdata, // fetched word
  input wire logic dmem_req, // data req
  input wire logic dmem_we, // write
  input wire logic [1:0] dmem_size, // size
  input wire logic [31:0] dmem_addr, // data addr
  input wire logic [31:0] dmem_wdata, // write data
  output logic dmem_ack, // data done
  output logic [31:0] dmem_rdata, // read data
  output logic irq_req, // irq pending
  output logic [13:0] irq_offset, // handler offset
  input wire logic irq_ack // irq taken
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0] iw;
  logic [1:0] dw;
  function automatic logic [31:0] rd(input logic [31:0] a);
    rd = mem.exists({a[31:2], 2'h0}) ? mem[{a[31:2], 2'h0}] : 32'h0;
  endfunction
  // fetch port; idle data lines toggle so stale words never look valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      imem_ack <= 1'b0;
      imem_rdata <= 32'h0;
      iw <= 2'h0;
    end else if (imem_req && !imem_ack && iw == 2'h0) begin
      imem_ack <= 1'b1;
      imem_rdata <= rd(imem_addr);
      iw <= 2'($urandom_range(max_wait, 0));
    end else begin
      imem_ack <= 1'b0;
      imem_rdata <= ~imem_rdata;
      if (imem_req && !imem_ack) iw <= iw - 2'h1;
    end
  end
  // data port; stores are taken whole-word only, enough for this bench
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dmem_ack <= 1'b0;
      dmem_rdata <= 32'h0;
      dw <= 2'h0;
    end else if (dmem_req && !dmem_ack && dw == 2'h0) begin
      dmem_ack <= 1'b1;
      dmem_rdata <= (rd(dmem_addr) >> {dmem_addr[1:0], 3'h0}) & (dmem_size == `SZ_B ?
        `MASK_B : dmem_size == `SZ_H ? `MASK_H : 32'hFFFFFFFF);
      if (dmem_we) mem[{dmem_addr[31:2], 2'h0}] = dmem_wdata;
      dw <= 2'($urandom_range(max_wait, 0));
    end else begin
      dmem_ack <= 1'b0;
      dmem_rdata <= ~dmem_rdata;
      if (dmem_req && !dmem_ack) dw <= dw - 2'h1;
    end
  end
  // interrupt held until taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
      irq_offset <= ~IRQ_OFS;
    end else if (irq_go) begin
      irq_req <= 1'b1;
      irq_offset <= IRQ_OFS;
    end else if (irq_ack) begin
      irq_req <= 1'b0;
      irq_offset <= ~IRQ_OFS;
    end
  end
endmodule // cpe_mem_model

// ### verif/cpe_core_tb.sv
`include "cpe_map.vh"
// ==========
// bench top
module cpe_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic irq_go = 1'b0;
  logic [1:0] max_wait = 2'h0;
  logic imem_req, imem_ack, dmem_req, dmem_we, dmem_ack, irq_req, irq_ack, retire;
  logic [31:0] imem_addr, imem_rdata, dmem_addr, dmem_wdata, dmem_rdata, retire_pc, status;
  logic [1:0] dmem_size;
  logic [13:0] irq_offset;
  logic [31:0] pc_q[$];
  logic [31:0] hpc_q[$];
  logic [95:0] wr_q[$];
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  cpe_core dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .imem_req(imem_req),
    .imem_addr(imem_addr), .imem_ack(imem_ack), .imem_rdata(imem_rdata), .dmem_req(dmem_req),
    .dmem_we(dmem_we), .dmem_size(dmem_size), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
    .dmem_ack(dmem_ack), .dmem_rdata(dmem_rdata), .irq_req(irq_req), .irq_offset(irq_offset),
    .irq_ack(irq_ack), .retire(retire), .retire_pc(retire_pc), .status(status));
  cpe_mem_model pm (.clk(clk), .rst_n(rst_n), .max_wait(max_wait), .irq_go(irq_go),
    .imem_req(imem_req), .imem_addr(imem_addr), .imem_ack(imem_ack), .imem_rdata(imem_rdata),
    .dmem_req(dmem_req), .dmem_we(dmem_we), .dmem_size(dmem_size), .dmem_addr(dmem_addr),
    .dmem_wdata(dmem_wdata), .dmem_ack(dmem_ack), .dmem_rdata(dmem_rdata), .irq_req(irq_req),
    .irq_offset(irq_offset), .irq_ack(irq_ack));
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk_retire(logic [31:0] e, logic [31:0] got);
    num_checks++;
    if (got !== e) begin
      n_mismatch++;
      $display("MISMATCH retire_pc expected %h seen %h", e, got);
    end
  endtask
  task automatic chk_write(logic [95:0] e, logic [31:0] a, logic [31:0] d);
    num_checks++;
    if (a !== e[95:64] || ((d ^ e[63:32]) & e[31:0]) !== 32'h0) begin
      n_mismatch++;
      $display("MISMATCH write expected %h:%h seen %h:%h", e[95:64], e[63:32], a, d);
    end
  endtask
  task automatic put(logic [31:0] a, logic [31:0] w);
    pm.mem[`RESET_PC + a] = w;
  endtask
  task automatic ew(logic [31:0] a, logic [31:0] d, logic [31:0] m = 32'hFFFFFFFF);
    wr_q.push_back({a, d, m});
  endtask
  task automatic phase(string name, int left);
    int i;
    for (i = 0; i < 4000 && (pc_q.size() > left || (left == 0 && wr_q.size() > 0)); i++)
      @(posedge clk);
    if (i == 4000) n_mismatch++;
    $display("test %s done", name);
  endtask
  // watcher: each retire and each data write against the oldest note
  always @(posedge clk) begin
    if (rst_n) begin
      cyc <= cyc + 1;
      if (retire === 1'b1 && retire_pc[31:12] === 20'h80001 && hpc_q.size() > 0)
        chk_retire(hpc_q.pop_front(), retire_pc);
      else if (retire === 1'b1 && retire_pc[31:12] !== 20'h80001 && pc_q.size() > 0)
        chk_retire(pc_q.pop_front(), retire_pc);
      if (dmem_req === 1'b1 && dmem_we === 1'b1 && dmem_ack === 1'b1)
        chk_write(wr_q.size() > 0 ? wr_q.pop_front() : 96'h0, dmem_addr, dmem_wdata);
      if (cyc > 20000) begin
        n_mismatch++;
        summarize();
      end
    end
  end
  // program image, notes, then three phases at prompt, random and slow memory
  initial begin
    logic [31:0] r12v;
    int i;
    void'($urandom(24));
    r12v = $urandom & 32'h7FFF;
    put(32'h0, 32'h51000100);
    put(32'h4, 32'h52100003);
    put(32'h8, 32'h63120000);
    put(32'hC, 32'h83130004);
    put(32'h10, 32'h75130004);
    put(32'h14, 32'h85120010);
    put(32'h18, 32'h77110001);
    put(32'h1C, 32'h58000088);
    put(32'h20, 32'h5C000000 | r12v);
    // aligned halfword load, so the halfword alignment check sees real traffic
    put(32'h24, 32'h7A110001);
    put(32'h60, 32'h88020200);
    put(32'h64, 32'h8C020204);
    put(32'h68, 32'h59008000);
    put(32'h6C, 32'hC0000000);
    put(32'h70, 32'h89920000);
    put(32'h74, 32'h90000000);
    put(32'h78, 32'h89020304);
    put(32'h1014, 32'h59000300);
    put(32'h1018, 32'h51100001);
    put(32'h101C, 32'hA0000000);
    put(32'h1100, 32'hB0000000);
    put(32'h1200, 32'h58000055);
    put(32'h1204, 32'hA0000000);
    for (i = 0; i <= 32'h78; i += 4) if (i != 32'h74) pc_q.push_back(`RESET_PC + i);
    hpc_q = '{32'h80001018, 32'h80001200, 32'h80001014, 32'h80001018};
    ew(32'h104, 32'h10300);
    ew(32'h108, 32'h0);
    ew(32'h110, 32'h10300);
    ew(32'hFFFC, `RESET_PC + 32'h18);
    ew(32'hFFF8, `SR_RESET);
    ew(32'hFFFC, r12v);
    for (i = 0; i < 3; i++) ew(32'hFFF8 - 4 * i, 32'h0);
    ew(32'hFFEC, 32'h88);
    ew(32'hFFE8, 32'h0, 32'h0);
    ew(32'hFFE4, `SR_RESET);
    ew(32'h200, 32'h88);
    ew(32'h204, r12v);
    ew(32'hFFFC, `RESET_PC + 32'h70);
    ew(32'hFFF8, 32'h0);
    ew(32'h300, 32'h300);
    ew(32'hFFFC, `RESET_PC + 32'h78);
    ew(32'hFFF8, 32'h0);
    ew(32'h304, 32'h300);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    phase("order, doubleword split, misaligned half", 21);
    max_wait <= 2'($urandom_range(3, 0));
    irq_go <= 1'b1;
    @(posedge clk);
    irq_go <= 1'b0;
    phase("interrupt frame push and restore", 4);
    max_wait <= 2'h3;
    phase("protection fault and system call", 0);
    summarize();
  end
endmodule // cpe_core_tb
